//--- sim/timer16_control_and_events_tb_top.sv
// Self-checking bench of the timer control and event block
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defs.vh"
module timer16_control_and_events_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic halt = 1'b0, waitm = 1'b0, mask = 1'b1, ext_run = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rv, c0;
	logic [31:0] rnd;
	wire [7:0] rdata;
	wire cap1, cap2, extp, irq, wake, p1, p1_oe_n, p2, p2_oe_n;
	int n_mismatch = 0, comparisons = 0, cyc = 0, seed = 54, t;
	logic [1:0] sels [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	int divs [4] = '{4, 2, 8, 8};
	logic [7:0] ra [7] = '{`ADR_CTL2, `ADR_CTL1, `ADR_CMP1_HI, `ADR_CMP1_LO, `ADR_CMP2_HI, `ADR_CMP2_LO, 8'h30};
	logic [7:0] rsv [7] = '{8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
	timer16_control_and_events #(.EXT_PIN_PRESENT(1)) u_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
		.o_rdata(rdata), .i_capture_input_one(cap1), .i_capture_input_two(cap2),
		.i_external_count_pin(extp), .i_halt(halt), .i_wait(waitm), .i_irq_mask(mask),
		.o_irq(irq), .o_wake(wake), .o_compare_pin_one(p1), .o_compare_pin_one_oe_n(p1_oe_n),
		.o_compare_pin_two(p2), .o_compare_pin_two_oe_n(p2_oe_n));
	timer_pin_env u_env (.i_clk(clk), .i_run(ext_run), .o_capture_input_one(cap1),
		.o_capture_input_two(cap2), .o_external_count_pin(extp));
	always #50 clk = ~clk;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Bus cycles; the trailing step keeps a strobe from being set twice at one edge
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Overflow arrives three to four counts after a reload; slack for pin sync
	function automatic logic in_range(input int n, input int div, input logic ext);
		return n >= 3 * div + 1 && n <= 4 * div + 4 + (ext ? 6 : 0);
	endfunction
	task automatic wait_irq(output int n);
		tick(2);
		#1;
		n = 2;
		while (irq !== 1'b1 && n < 100) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Cuts a hang short; the whole run needs well under this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		tick(3);
		rst_n <= 1'b1;
		tick(1);
		wreg(8'h30, 8'hff);
		foreach (ra[i]) begin
			rreg(ra[i], rv);
			check(rv, rsv[i]);
		end
		rreg(`ADR_STAT, rv);
		check(rv[2:0], 3'b000);
		$display("end of reset values");
		mask <= 1'b0;
		wreg(`ADR_CTL1, 8'h20);
		foreach (sels[i]) begin
			ext_run <= (sels[i] == 2'h3);
			wreg(`ADR_CTL2, {4'h0, sels[i], 2'b01});
			rreg(`ADR_STAT, rv);
			wreg(`ADR_CNT_LO, 8'h00);
			wait_irq(t);
			check(in_range(t, divs[i], sels[i] == 2'h3), 1'b1);
		end
		ext_run <= 1'b0;
		mask <= 1'b1;
		tick(2);
		check(irq, 1'b0);
		mask <= 1'b0;
		wreg(`ADR_CTL1, 8'h00);
		tick(2);
		check(irq, 1'b0);
		$display("end of clock select");
		wreg(`ADR_CTL1, 8'h80);
		wreg(`ADR_CTL2, 8'h02);
		u_env.set_cap(1, 1'b1);
		tick(8);
		rreg(`ADR_STAT, rv);
		check(rv[7], 1'b0);
		u_env.set_cap(1, 1'b0);
		u_env.set_cap(2, 1'b1);
		tick(8);
		rreg(`ADR_STAT, rv);
		check({rv[7], rv[4], irq}, 3'b111);
		rreg(`ADR_CAP1_LO, rv);
		rreg(`ADR_STAT, rv);
		check(rv[7:4], 4'h3);
		rreg(`ADR_CAP2_LO, rv);
		rreg(`ADR_STAT, rv);
		check(rv[4], 1'b0);
		$display("end of capture");
		wreg(`ADR_CTL1, 8'ha0);
		wreg(`ADR_CTL2, 8'h00);
		halt <= 1'b1;
		waitm <= 1'b1;
		rreg(`ADR_ALT_LO, c0);
		tick(20);
		rreg(`ADR_ALT_LO, rv);
		check(rv, c0);
		u_env.set_cap(2, 1'b0);
		tick(10);
		rreg(`ADR_STAT, rv);
		check({rv[4], wake}, 2'b00);
		halt <= 1'b0;
		mask <= 1'b1;
		tick(3);
		rreg(`ADR_STAT, rv);
		check({rv[4], wake}, 2'b11);
		rreg(`ADR_ALT_LO, c0);
		tick(20);
		rreg(`ADR_ALT_LO, rv);
		check(rv != c0, 1'b1);
		waitm <= 1'b0;
		mask <= 1'b0;
		rreg(`ADR_CAP2_LO, rv);
		$display("end of halt and wait");
		wreg(`ADR_CTL2, 8'hc0);
		wreg(`ADR_STAT, 8'hff);
		rreg(`ADR_STAT, rv);
		check(rv[2:0], 3'b100);
		rreg(`ADR_ALT_LO, c0);
		tick(30);
		rreg(`ADR_ALT_LO, rv);
		check({rv, p1_oe_n, p2_oe_n}, {c0, 2'b11});
		wreg(`ADR_STAT, 8'h00);
		check({p1_oe_n, p2_oe_n}, 2'b00);
		$display("end of freeze");
		wreg(`ADR_CTL1, 8'h45);
		wreg(`ADR_CMP1_HI, 8'h00);
		wreg(`ADR_CMP1_LO, 8'h02);
		wreg(`ADR_CMP2_HI, 8'h00);
		wreg(`ADR_CMP2_LO, 8'h04);
		wreg(`ADR_CNT_LO, 8'h00);
		rreg(`ADR_STAT, rv);
		tick(60);
		rreg(`ADR_CMP1_LO, rv);
		rreg(`ADR_STAT, rv);
		check({rv[6], rv[3], p1, p2, irq}, 5'h1f);
		rreg(`ADR_CMP1_LO, rv);
		rreg(`ADR_CMP2_LO, rv);
		rreg(`ADR_STAT, rv);
		check({rv[6], rv[3]}, 2'b00);
		$display("end of compare");
		wreg(`ADR_CTL1, 8'h81);
		wreg(`ADR_CTL2, 8'hd0);
		wreg(`ADR_CNT_LO, 8'h00);
		tick(80);
		rreg(`ADR_STAT, rv);
		check({rv[7], rv[6], rv[3], irq}, 4'h9);
		$display("end of pulse width");
		repeat (30) begin
			rnd = $random(seed);
			wreg(`ADR_CTL1, rnd[7:0]);
			wreg(`ADR_CTL2, rnd[15:8] & 8'hf3);
			tick(2);
			rreg(`ADR_CTL1, rv);
			check(rv, rnd[7:0]);
			if (rnd[3] && rnd[15] && rnd[13:12] == 2'h0)
				check(p1, rnd[0]);
			if (rnd[4] && rnd[14] && rnd[13:12] == 2'h0)
				check(p2, rnd[2]);
		end
		$display("end of random control");
		complete_run();
	end
endmodule // timer16_control_and_events_tb_top
`default_nettype wire

//--- sim/timer16_ctl_asserts.sv
// Port assertions of the timer control and event block
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defs.vh"
module timer16_ctl_asserts (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_halt,
	input wire logic i_irq_mask,
	input wire logic o_irq,
	input wire logic o_wake,
	input wire logic o_compare_pin_one,
	input wire logic o_compare_pin_one_oe_n,
	input wire logic o_compare_pin_two,
	input wire logic o_compare_pin_two_oe_n
);
	logic [7:0] ctl1_r, ctl2_r;
	logic frz_r;
	wire frc1 = ctl1_r[3] && ctl2_r[7] && ctl2_r[5:4] == 2'h0 && !frz_r;
	wire frc2 = ctl1_r[4] && ctl2_r[6] && ctl2_r[5:4] == 2'h0 && !frz_r;
	// Shadows of software-owned bits, so pins can be tied to their cause
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl1_r <= 8'h00;
			ctl2_r <= 8'h00;
			frz_r <= 1'b0;
		end else if (i_wr) begin
			if (i_addr == `ADR_CTL1)
				ctl1_r <= i_wdata;
			if (i_addr == `ADR_CTL2)
				ctl2_r <= i_wdata;
			if (i_addr == `ADR_STAT)
				frz_r <= i_wdata[`BS_FREEZE];
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_rd(a); i_rd && i_addr == a; endsequence
	property p_irq_mask; o_irq |-> !$past(i_irq_mask); endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
	property p_irq_off; $past(ctl1_r[7:5]) == 3'h0 |-> !o_irq; endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with enables off");
	property p_stat_rd; s_rd(`ADR_STAT) |=> o_rdata[2:0] == {frz_r, 2'b00}; endproperty
	a_stat_rd: assert property (p_stat_rd) else $error("status low bits wrong");
	property p_ctl_rd; s_rd(`ADR_CTL2) |=> o_rdata == $past(ctl2_r); endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control two readback");
	property p_frz_oe; frz_r |-> o_compare_pin_one_oe_n && o_compare_pin_two_oe_n; endproperty
	a_frz_oe: assert property (p_frz_oe) else $error("pins driven while frozen");
	property p_frz_hold; frz_r && $past(frz_r) |-> $stable(o_compare_pin_one) && $stable(o_compare_pin_two); endproperty
	a_frz_hold: assert property (p_frz_hold) else $error("pin moved while frozen");
	property p_oe; !frz_r |-> o_compare_pin_one_oe_n == !ctl2_r[7] && o_compare_pin_two_oe_n == !ctl2_r[6]; endproperty
	a_oe: assert property (p_oe) else $error("pin enable mismatch");
	property p_halt; i_halt |-> !o_wake; endproperty
	a_halt: assert property (p_halt) else $error("wake during halt");
	property p_frc1; $past(frc1) |-> o_compare_pin_one == $past(ctl1_r[0]); endproperty
	a_frc1: assert property (p_frc1) else $error("forced pin one");
	property p_frc2; $past(frc2) |-> o_compare_pin_two == $past(ctl1_r[2]); endproperty
	a_frc2: assert property (p_frc2) else $error("forced pin two");
endmodule // timer16_ctl_asserts
bind timer16_control_and_events timer16_ctl_asserts u_chk (.*);
`default_nettype wire

//--- sim/timer_pin_env.sv
// Model of the pins outside the timer: capture lines and external count clock
`timescale 1ns/1ns
`default_nettype none
module timer_pin_env (
	input wire logic i_clk,
	input wire logic i_run,
	output logic o_capture_input_one,
	output logic o_capture_input_two,
	output logic o_external_count_pin
);
	logic [1:0] ph_r = 2'h0;
	initial begin
		o_capture_input_one = 1'b0;
		o_capture_input_two = 1'b0;
		o_external_count_pin = 1'b0;
	end
	// Count clock of eight CPU cycles; holds its level while not enabled
	always @(posedge i_clk) begin
		if (i_run) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h3)
				o_external_count_pin <= ~o_external_count_pin;
		end
	end
	// Capture line levels, changed right after a clock edge
	task automatic set_cap(input int which, input logic v);
		if (which == 1)
			o_capture_input_one <= v;
		else
			o_capture_input_two <= v;
	endtask
endmodule // timer_pin_env
`default_nettype wire

//--- verilog/pin_sync3.v
// Three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ns
`default_nettype none
module pin_sync3 #(
	parameter WIDTH = 3
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire [WIDTH-1:0] i_async,
	output reg [WIDTH-1:0] o_level
);
	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] mid_r;
	reg [WIDTH-1:0] late_r;

	// First stage feeds only the second one
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= {WIDTH{1'b0}};
			mid_r <= {WIDTH{1'b0}};
			late_r <= {WIDTH{1'b0}};
		end else begin
			meta_r <= i_async;
			mid_r <= meta_r;
			late_r <= mid_r;
		end
	end

	// Accept a change only once two stages agree, which drops one-cycle glitches
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_agree
			always @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n)
					o_level[g] <= 1'b0;
				else if (mid_r[g] == late_r[g])
					o_level[g] <= late_r[g];
			end
		end
	endgenerate
endmodule // pin_sync3
`default_nettype wire

//--- verilog/timer16_control_and_events.v
// Control, status, counting and event logic of the 16-bit timer
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defs.vh"
module timer16_control_and_events #(
	parameter EXT_PIN_PRESENT = 1
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [7:0] o_rdata,
	input wire i_capture_input_one,
	input wire i_capture_input_two,
	input wire i_external_count_pin,
	input wire i_halt,
	input wire i_wait,
	input wire i_irq_mask,
	output reg o_irq,
	output wire o_wake,
	output wire o_compare_pin_one,
	output wire o_compare_pin_one_oe_n,
	output wire o_compare_pin_two,
	output wire o_compare_pin_two_oe_n
);
	// Software-visible registers, counter and compare inhibit
	reg [7:0] ctl_one_r;
	reg [7:0] ctl_two_r;
	reg timer_freeze_r;
	reg [15:0] count_r;
	reg [15:0] count_nxt;
	reg [15:0] compare_value_one_r;
	reg [15:0] compare_value_two_r;
	reg [15:0] capture_value_one_r;
	reg [15:0] capture_value_two_r;
	reg [1:0] compare_hold_r;

	// Flag, clear-arming and HALT state
	reg [4:0] flags_r;
	reg [4:0] clear_arm_r;
	reg [1:0] halt_arm_r;
	reg halt_d_r;

	// Pin history and compare pin levels
	reg [2:0] pin_prev_r;
	reg pin_one_r;
	reg pin_one_nxt;
	reg pin_two_r;
	reg pin_two_nxt;

	// Read path and internal event wires
	reg [7:0] rdata_nxt;
	wire [2:0] pin_lvl;
	wire pre_tick;
	wire [4:0] flag_set;
	wire [4:0] low_access;

	// Control fields
	wire capture_irq_enable = ctl_one_r[`B1_CAP_IE];
	wire compare_irq_enable = ctl_one_r[`B1_CMP_IE];
	wire overflow_irq_enable = ctl_one_r[`B1_OVF_IE];
	wire force_out_two = ctl_one_r[`B1_FRC2];
	wire force_out_one = ctl_one_r[`B1_FRC1];
	wire level_out_two = ctl_one_r[`B1_LVL2];
	wire capture_edge_one = ctl_one_r[`B1_EDG1];
	wire level_out_one = ctl_one_r[`B1_LVL1];
	wire compare_pin_en_one = ctl_two_r[`B2_PEN1];
	wire compare_pin_en_two = ctl_two_r[`B2_PEN2];
	wire single_pulse_mode = ctl_two_r[`B2_OPM];
	wire pulse_width_mode = ctl_two_r[`B2_PWM];
	wire [1:0] clock_select = {ctl_two_r[`B2_CKS_HI], ctl_two_r[`B2_CKS_LO]};
	wire capture_edge_two = ctl_two_r[`B2_EDG2];
	wire ext_clock_edge = ctl_two_r[`B2_EXT_CLOCK_EDGE];

	// Edge of a synchronised pin in the chosen direction, 1 rising
	function edge_hit;
		input sel;
		input now;
		input prev;
		begin
			edge_hit = sel ? (now & ~prev) : (~now & prev);
		end
	endfunction

	// Which flag a clearing low-byte access belongs to; alternate counter excluded
	function [4:0] flag_of_addr;
		input [7:0] addr;
		begin
			flag_of_addr = 5'h00;
			case (addr)
				`ADR_CAP1_LO: flag_of_addr[`FLG_CAP1] = 1'b1;
				`ADR_CMP1_LO: flag_of_addr[`FLG_CMP1] = 1'b1;
				`ADR_CNT_LO: flag_of_addr[`FLG_OVF] = 1'b1;
				`ADR_CAP2_LO: flag_of_addr[`FLG_CAP2] = 1'b1;
				`ADR_CMP2_LO: flag_of_addr[`FLG_CMP2] = 1'b1;
				default: flag_of_addr = 5'h00;
			endcase
		end
	endfunction

	// Pins cross into the CPU clock domain
	// Edge detection below reads only the agreed level, never a raw pin
	pin_sync3 #(
		.WIDTH(3)
	) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_external_count_pin, i_capture_input_two, i_capture_input_one}),
		.o_level(pin_lvl)
	);

	// Counting runs unless frozen or halted; WAIT has no effect here
	wire run = ~timer_freeze_r & ~i_halt;

	timer_prescaler u_pre (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(run),
		.i_select(clock_select),
		.o_tick(pre_tick)
	);

	// Pin edges in the selected direction
	wire cap_one_edge = edge_hit(capture_edge_one, pin_lvl[0], pin_prev_r[0]);
	wire cap_two_edge = edge_hit(capture_edge_two, pin_lvl[1], pin_prev_r[1]);
	wire ext_edge = edge_hit(ext_clock_edge, pin_lvl[2], pin_prev_r[2]);

	// Without the pin, external select leaves the counter stopped
	wire ext_tick = run && (clock_select == `CKS_EXT) && (EXT_PIN_PRESENT != 0) && ext_edge;
	// A prescaler tick already in flight as HALT or freeze starts is dropped,
	// so the count read at that edge is the one that stays held
	wire pre_gated = pre_tick & run;
	wire tick = pre_gated | ext_tick;

	// Mode decode: pulse-width wins when both modes are set
	// Capture one is given over to whichever pulse mode runs
	wire pwm_on = pulse_width_mode;
	wire opm_on = single_pulse_mode & ~pulse_width_mode;

	// Compare matches on the value the counter is stepping to
	// so flag, pin and count all change at the same edge
	wire [15:0] count_inc = count_r + `CNT_ONE;
	wire match_one = tick && (count_inc == compare_value_one_r) && !compare_hold_r[0];
	wire match_two = tick && (count_inc == compare_value_two_r) && !compare_hold_r[1];
	wire halt_exit = halt_d_r & ~i_halt;
	wire opm_start = opm_on & cap_one_edge & run;
	wire pwm_restart = pwm_on & match_two;
	wire cap_one_event = cap_one_edge & ~i_halt & ~opm_on & ~pwm_on;
	wire cap_two_event = cap_two_edge & ~i_halt;
	wire wr_cnt = i_wr && ((i_addr == `ADR_CNT_LO) || (i_addr == `ADR_ALT_LO));

	// Hardware events that set the five flags
	assign flag_set[`FLG_CAP1] = cap_one_event | opm_start | pwm_restart | (halt_exit & halt_arm_r[0]);
	assign flag_set[`FLG_CMP1] = match_one & ~opm_on & ~pwm_on;
	assign flag_set[`FLG_OVF] = tick && (count_inc == `CNT_WRAP) && !pwm_restart;
	assign flag_set[`FLG_CAP2] = cap_two_event | (halt_exit & halt_arm_r[1]);
	assign flag_set[`FLG_CMP2] = match_two & ~pwm_on;

	assign low_access = (i_rd | i_wr) ? flag_of_addr(i_addr) : 5'h00;
	wire status_rd = i_rd && (i_addr == `ADR_STAT);

	// One sticky flag each, with its own clear arming
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_flag
			always @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					flags_r[g] <= 1'b0;
					clear_arm_r[g] <= 1'b0;
				end else begin
					// Arm only if the flag was seen set by the status read
					if (status_rd)
						clear_arm_r[g] <= flags_r[g];
					else if (low_access[g])
						clear_arm_r[g] <= 1'b0;
					// Set beats a clear landing in the same cycle
					if (flag_set[g])
						flags_r[g] <= 1'b1;
					else if (low_access[g] && clear_arm_r[g])
						flags_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Counter: software write or mode restart reload, else advance on tick
	// A reload beats a tick that lands in the same cycle
	always @* begin
		count_nxt = count_r;
		if (wr_cnt || opm_start || pwm_restart)
			count_nxt = `CNT_RESET;
		else if (tick)
			count_nxt = count_inc;
	end

	// Pin one level per mode; forced copy only in plain compare mode
	always @* begin
		pin_one_nxt = pin_one_r;
		if (pwm_on) begin
			if (match_two)
				pin_one_nxt = level_out_two;
			else if (match_one)
				pin_one_nxt = level_out_one;
		end else if (opm_on) begin
			if (opm_start)
				pin_one_nxt = level_out_two;
			else if (match_one)
				pin_one_nxt = level_out_one;
		end else if (force_out_one || match_one) begin
			pin_one_nxt = level_out_one;
		end
	end

	// Pin two only follows compare two outside the pulse modes
	always @* begin
		pin_two_nxt = pin_two_r;
		if (!pwm_on && !opm_on && (force_out_two || match_two))
			pin_two_nxt = level_out_two;
	end

	// Enables only hand over the pin; freeze also releases it
	assign o_compare_pin_one = pin_one_r;
	assign o_compare_pin_two = pin_two_r;
	assign o_compare_pin_one_oe_n = ~(compare_pin_en_one & ~timer_freeze_r);
	assign o_compare_pin_two_oe_n = ~(compare_pin_en_two & ~timer_freeze_r);

	// Shared request with per-group enables
	// Registered, so o_irq trails its flag by one cycle
	wire pending = (capture_irq_enable & (flags_r[`FLG_CAP1] | flags_r[`FLG_CAP2]))
		| (compare_irq_enable & (flags_r[`FLG_CMP1] | flags_r[`FLG_CMP2]))
		| (overflow_irq_enable & flags_r[`FLG_OVF]);

	// Wake from WAIT regardless of the global mask; events never end HALT
	assign o_wake = i_wait & ~i_halt & pending;

	// Timing, pins, captures and mode outputs
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_r <= `CNT_RESET;
			pin_prev_r <= 3'h0;
			halt_d_r <= 1'b0;
			halt_arm_r <= 2'h0;
			pin_one_r <= 1'b0;
			pin_two_r <= 1'b0;
			capture_value_one_r <= `CAP_RESET;
			capture_value_two_r <= `CAP_RESET;
			o_irq <= 1'b0;
		end else begin
			count_r <= count_nxt;
			pin_prev_r <= pin_lvl;
			halt_d_r <= i_halt;
			o_irq <= pending & ~i_irq_mask;
			// Compare logic runs whatever the pin enables say
			if (!timer_freeze_r) begin
				pin_one_r <= pin_one_nxt;
				pin_two_r <= pin_two_nxt;
			end
			// Edges seen during HALT are held until the wake
			if (halt_exit)
				halt_arm_r <= 2'h0;
			else if (i_halt)
				halt_arm_r <= halt_arm_r | {cap_two_edge, cap_one_edge & ~opm_on & ~pwm_on};
			// Capture takes the count present at the event or at HALT exit; a single-pulse start loads CAP_OPM into capture one
			if (opm_start)
				capture_value_one_r <= `CAP_OPM;
			else if (cap_one_event || (halt_exit && halt_arm_r[0]))
				capture_value_one_r <= count_r;
			if (cap_two_event || (halt_exit && halt_arm_r[1]))
				capture_value_two_r <= count_r;
		end
	end

	// Register writes; a high compare byte inhibits matching until its low byte
	// Capture and counter bytes are read-only; a counter low write reloads
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctl_one_r <= `CTL_RESET;
			ctl_two_r <= `CTL_RESET;
			timer_freeze_r <= 1'b0;
			compare_value_one_r <= `CMP_RESET;
			compare_value_two_r <= `CMP_RESET;
			compare_hold_r <= 2'h0;
		end else if (i_wr) begin
			case (i_addr)
				`ADR_CTL1: ctl_one_r <= i_wdata;
				`ADR_CTL2: ctl_two_r <= i_wdata;
				`ADR_STAT: timer_freeze_r <= i_wdata[`BS_FREEZE];
				`ADR_CMP1_HI: begin
					compare_value_one_r[15:8] <= i_wdata;
					compare_hold_r[0] <= 1'b1;
				end
				`ADR_CMP1_LO: begin
					compare_value_one_r[7:0] <= i_wdata;
					compare_hold_r[0] <= 1'b0;
				end
				`ADR_CMP2_HI: begin
					compare_value_two_r[15:8] <= i_wdata;
					compare_hold_r[1] <= 1'b1;
				end
				`ADR_CMP2_LO: begin
					compare_value_two_r[7:0] <= i_wdata;
					compare_hold_r[1] <= 1'b0;
				end
				default: compare_hold_r <= compare_hold_r;
			endcase
		end
	end

	// Read mux; flags read-only and low two status bits zero
	always @* begin
		case (i_addr)
			`ADR_CTL1: rdata_nxt = ctl_one_r;
			`ADR_CTL2: rdata_nxt = ctl_two_r;
			`ADR_STAT: rdata_nxt = {flags_r, timer_freeze_r, 2'h0};
			`ADR_CAP1_HI: rdata_nxt = capture_value_one_r[15:8];
			`ADR_CAP1_LO: rdata_nxt = capture_value_one_r[7:0];
			`ADR_CMP1_HI: rdata_nxt = compare_value_one_r[15:8];
			`ADR_CMP1_LO: rdata_nxt = compare_value_one_r[7:0];
			`ADR_CNT_HI: rdata_nxt = count_r[15:8];
			`ADR_CNT_LO: rdata_nxt = count_r[7:0];
			`ADR_ALT_HI: rdata_nxt = count_r[15:8];
			`ADR_ALT_LO: rdata_nxt = count_r[7:0];
			`ADR_CAP2_HI: rdata_nxt = capture_value_two_r[15:8];
			`ADR_CAP2_LO: rdata_nxt = capture_value_two_r[7:0];
			`ADR_CMP2_HI: rdata_nxt = compare_value_two_r[15:8];
			`ADR_CMP2_LO: rdata_nxt = compare_value_two_r[7:0];
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data stand only in the cycle after the strobe
	// Zero otherwise, so the bus can be ORed with other slaves
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_rdata <= 8'h00;
		else if (i_rd)
			o_rdata <= rdata_nxt;
		else
			o_rdata <= 8'h00;
	end
endmodule // timer16_control_and_events
`default_nettype wire

//--- verilog/timer16_defs.vh
// Register map, field positions, codes and reset values of the 16-bit timer
// Behaviour
// - WAIT leaves timer running; enabled interrupt wakes
// - HALT stops counter; resume held or reset
// - Capture edge in HALT arms capture at wake
// - All events share one masked interrupt request
// - Capture enable gates both capture flags
// - Compare enable gates both compare flags
// - Overflow enable gates overflow flag
// - Forced output two copies level two
// - Forced output one copies level one
// - Level two on match two; pin one in modes
// - Capture edge select: 0 falling, 1 rising
// - Level one driven on compare one match
// - Pin enables hand pins; compares keep running
// - Single-pulse: capture edge starts one pulse
// - Pulse-width: value one length, two period
// - Clock select: /4, /2, /8, external
// - Missing external pin: external select stops counter
// - External clock edge: 0 falling, 1 rising
// - Capture flag one; cleared by status, low byte
// - Compare flag one; cleared by status, low byte
// - Overflow flag on wrap; status then counter low
// - Status flags read-only; only freeze writable
// - Freeze stops prescaler, counter and outputs
// - Capture flag two; status then low byte
// - Compare flag two; status then low byte
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
`define ADR_CTL2 8'h31
`define ADR_CTL1 8'h32
`define ADR_STAT 8'h33
`define ADR_CAP1_HI 8'h34
`define ADR_CAP1_LO 8'h35
`define ADR_CMP1_HI 8'h36
`define ADR_CMP1_LO 8'h37
`define ADR_CNT_HI 8'h38
`define ADR_CNT_LO 8'h39
`define ADR_ALT_HI 8'h3a
`define ADR_ALT_LO 8'h3b
`define ADR_CAP2_HI 8'h3c
`define ADR_CAP2_LO 8'h3d
`define ADR_CMP2_HI 8'h3e
`define ADR_CMP2_LO 8'h3f
`define B1_CAP_IE 7
`define B1_CMP_IE 6
`define B1_OVF_IE 5
`define B1_FRC2 4
`define B1_FRC1 3
`define B1_LVL2 2
`define B1_EDG1 1
`define B1_LVL1 0
`define B2_PEN1 7
`define B2_PEN2 6
`define B2_OPM 5
`define B2_PWM 4
`define B2_CKS_HI 3
`define B2_CKS_LO 2
`define B2_EDG2 1
`define B2_EXT_CLOCK_EDGE 0
`define BS_FREEZE 2
`define FLG_CAP1 4
`define FLG_CMP1 3
`define FLG_OVF 2
`define FLG_CAP2 1
`define FLG_CMP2 0
`define CKS_DIV4 2'h0
`define CKS_DIV2 2'h1
`define CKS_DIV8 2'h2
`define CKS_EXT 2'h3
`define DIV2_MASK 3'h1
`define DIV4_MASK 3'h3
`define DIV8_MASK 3'h7
`define CTL_RESET 8'h00
`define CNT_RESET 16'hfffc
`define CAP_OPM 16'hfffd
`define CNT_WRAP 16'h0000
`define CNT_ONE 16'h0001
`define CMP_RESET 16'h8000
`define CAP_RESET 16'h0000
`endif

//--- verilog/timer_prescaler.v
// Prescaler giving one-cycle count enables at CPU/2, /4 or /8
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defs.vh"
module timer_prescaler (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_run,
	input wire [1:0] i_select,
	output reg o_tick
);
	reg [2:0] div_r;
	reg [2:0] mask;

	// Ratio mask; external select yields no prescaled tick
	always @* begin
		case (i_select)
			`CKS_DIV4: mask = `DIV4_MASK;
			`CKS_DIV2: mask = `DIV2_MASK;
			`CKS_DIV8: mask = `DIV8_MASK;
			default: mask = `DIV8_MASK;
		endcase
	end

	// Divider holds its phase while stopped so no partial period is lost
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_r <= 3'h0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= 1'b0;
			if (i_run) begin
				div_r <= div_r + 3'h1;
				o_tick <= ((div_r & mask) == mask) && (i_select != `CKS_EXT);
			end
		end
	end
endmodule // timer_prescaler
`default_nettype wire
